//--- core/usart_core.sv
// Serial transceiver core: data, divider and frame control behind an AHB-Lite slave.
// Assumes single word transfers, inputs synchronous to clk, rxd already synchronised.
//
// Summary of operation
// - Data register bits above the 9-bit word always read as zero.
// - Low nine data bits: write queues a transmit word, read returns received.
// - With parity on, transmitted MSB is replaced by the computed parity bit.
// - With parity on, the received parity bit appears as MSB of read word.
// - Baud counter stops when transmitter and receiver enables are both clear.
// - 16-bit divider in baud register low half, reset zero, upper half reads zero.
// - Control bit 13 enables the unit; resets to zero.
// - Control bit 12 selects 8 or 9 data bits for both directions.
// - Control bit 11 picks wake from silence: idle line or address match.
// - Control bit 10 enables parity generation and checking.
// - Control bit 9 picks even (0) or odd (1) parity.
// - Failed receive parity sets parity error flag in status bit 0.
`timescale 1ns/1ps

module usart_core
    import usart_core_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        rxd,
    output logic             txd,
    output logic             irq
);
    import usart_core_pkg::*;

    typedef struct packed {
        logic [31:0]       rdata;
        logic              rdy;
        logic              rd_pend;
        logic              wr_pend;
        logic [7:0]        addr;
        logic [DIV_W-1:0]  div;
        logic [13:0]       ctrl;
        logic [EV_W-1:0]   status;
        logic [EV_W-1:0]   mask;
        logic [NODE_W-1:0] node;
        logic              mute;
        logic              irq;
        logic [DIV_W-1:0]  baud_cnt;
        line_state_t       tx_st;
        logic [DATA_W-1:0] tx_hold;
        logic              tx_full;
        logic [DATA_W-1:0] tx_sr;
        logic [3:0]        tx_bits;
        logic              txd;
        line_state_t       rx_st;
        logic [DIV_W-1:0]  rx_cnt;
        logic [DATA_W-1:0] rx_sr;
        logic [3:0]        rx_bits;
        logic [3:0]        idle_bits;
        logic [DATA_W-1:0] rx_word;
    } state_t;

    state_t cur;
    state_t next_cur;

    logic              run;
    logic              tick;
    logic [DIV_W-1:0]  period;
    logic [3:0]        nbits;
    logic [DATA_W-1:0] tx_word;
    logic [DATA_W-1:0] rx_done_word;
    logic              rx_done;
    logic              rx_parity_error_flag;

    assign hrdata    = cur.rdata;
    assign hreadyout = cur.rdy;
    assign hresp     = 1'b0;
    assign txd       = cur.txd;
    assign irq       = cur.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Shared timing terms
    always_comb begin
        run    = cur.ctrl[CTRL_UEN] & (cur.ctrl[CTRL_TEN] | cur.ctrl[CTRL_REN]);
        period = (cur.div == 16'h0000) ? 16'h0001 : cur.div;
        tick   = run && (cur.baud_cnt == 16'h0000);
        nbits  = cur.ctrl[CTRL_WL] ? 4'h9 : 4'h8;
        // Parity replaces the MSB of the written word
        tx_word = cur.tx_hold;
        if (cur.ctrl[CTRL_PEN]) begin
            if (cur.ctrl[CTRL_WL]) begin
                tx_word[8] = (^cur.tx_hold[7:0]) ^ cur.ctrl[CTRL_PSEL];
            end else begin
                tx_word[7] = (^cur.tx_hold[6:0]) ^ cur.ctrl[CTRL_PSEL];
            end
        end
        // MSB of the stored word holds the received parity bit
        rx_done_word = cur.ctrl[CTRL_WL] ? cur.rx_sr : {1'b0, cur.rx_sr[8:1]};
        rx_done      = cur.rx_st == LINE_STOP && cur.rx_cnt == 16'h0000 && run;
        rx_parity_error_flag      = cur.ctrl[CTRL_PEN] && ((^rx_done_word) != cur.ctrl[CTRL_PSEL]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [EV_W-1:0] ev;
        logic            id_hit;
        next_cur = cur;
        ev       = '0;
        id_hit   = 1'b0;

        // Bus: reads take one wait state so a write just before is seen
        next_cur.rdy     = 1'b1;
        next_cur.rd_pend = 1'b0;
        next_cur.wr_pend = 1'b0;
        if (cur.rd_pend) begin
            next_cur.rdata = 32'h0000_0000;
            case (cur.addr)
                OFS_STATUS: next_cur.rdata = {27'h0, cur.mute, 1'b0, cur.status};
                OFS_DATA:   next_cur.rdata = {23'h0, cur.rx_word};
                OFS_BAUD:   next_cur.rdata = {16'h0, cur.div};
                OFS_CTRL:   next_cur.rdata = {18'h0, cur.ctrl};
                OFS_MASK:   next_cur.rdata = {29'h0, cur.mask};
                OFS_ADDR:   next_cur.rdata = {28'h0, cur.node};
                default:    next_cur.rdata = 32'h0000_0000;
            endcase
        end
        if (cur.wr_pend) begin
            case (cur.addr)
                OFS_DATA: begin
                    next_cur.tx_hold = hwdata[DATA_W-1:0];
                    next_cur.tx_full = 1'b1;
                end
                OFS_BAUD: next_cur.div = hwdata[DIV_W-1:0];
                OFS_CTRL: begin
                    next_cur.ctrl = hwdata[13:0] & CTRL_RW_MASK;
                    if (hwdata[CTRL_MUTE]) begin
                        next_cur.mute = 1'b1;
                    end
                end
                OFS_MASK: next_cur.mask = hwdata[EV_W-1:0];
                OFS_ADDR: next_cur.node = hwdata[NODE_W-1:0];
                default: ;
            endcase
        end
        if (hsel && hready && htrans[1]) begin
            next_cur.addr = haddr[7:0];
            if (hwrite) begin
                next_cur.wr_pend = 1'b1;
            end else begin
                next_cur.rd_pend = 1'b1;
                next_cur.rdy     = 1'b0;
            end
        end

        // Baud counter, frozen while neither direction is enabled
        if (run) begin
            next_cur.baud_cnt = tick ? period - 16'h0001 : cur.baud_cnt - 16'h0001;
        end

        // Transmitter
        case (cur.tx_st)
            LINE_IDLE: begin
                next_cur.txd = 1'b1;
                if (tick && cur.tx_full && cur.ctrl[CTRL_TEN]) begin
                    next_cur.tx_sr   = tx_word;
                    next_cur.tx_full = 1'b0;
                    next_cur.txd     = 1'b0;
                    next_cur.tx_st   = LINE_START;
                end
            end
            LINE_START: begin
                if (tick) begin
                    next_cur.txd     = cur.tx_sr[0];
                    next_cur.tx_sr   = {1'b0, cur.tx_sr[8:1]};
                    next_cur.tx_bits = 4'h1;
                    next_cur.tx_st   = LINE_DATA;
                end
            end
            LINE_DATA: begin
                if (tick) begin
                    if (cur.tx_bits == nbits) begin
                        next_cur.txd   = 1'b1;
                        next_cur.tx_st = LINE_STOP;
                    end else begin
                        next_cur.txd     = cur.tx_sr[0];
                        next_cur.tx_sr   = {1'b0, cur.tx_sr[8:1]};
                        next_cur.tx_bits = cur.tx_bits + 4'h1;
                    end
                end
            end
            LINE_STOP: begin
                if (tick) begin
                    ev[ST_TXDONE]  = 1'b1;
                    next_cur.tx_st = LINE_IDLE;
                end
            end
            default: next_cur.tx_st = LINE_IDLE;
        endcase

        // Receiver: rx_cnt is the phase counter inside a bit
        if (run && cur.ctrl[CTRL_REN]) begin
            next_cur.rx_cnt = (cur.rx_cnt == 16'h0000) ? period - 16'h0001 : cur.rx_cnt - 16'h0001;
            case (cur.rx_st)
                LINE_IDLE: begin
                    if (!rxd) begin
                        next_cur.rx_cnt    = {1'b0, period[15:1]};
                        next_cur.idle_bits = 4'h0;
                        next_cur.rx_st     = LINE_START;
                    end else if (cur.rx_cnt == 16'h0000 && cur.idle_bits != 4'hf) begin
                        next_cur.idle_bits = cur.idle_bits + 4'h1;
                    end
                end
                LINE_START: begin
                    if (cur.rx_cnt == 16'h0000) begin
                        // A glitch shorter than half a bit is not a start
                        next_cur.rx_st   = rxd ? LINE_IDLE : LINE_DATA;
                        next_cur.rx_bits = 4'h0;
                    end
                end
                LINE_DATA: begin
                    if (cur.rx_cnt == 16'h0000) begin
                        next_cur.rx_sr   = {rxd, cur.rx_sr[8:1]};
                        next_cur.rx_bits = cur.rx_bits + 4'h1;
                        if (cur.rx_bits + 4'h1 == nbits) begin
                            next_cur.rx_st = LINE_STOP;
                        end
                    end
                end
                LINE_STOP: begin
                    if (cur.rx_cnt == 16'h0000) begin
                        next_cur.rx_st = LINE_IDLE;
                        id_hit = rx_done_word[nbits-4'h1] && rx_done_word[NODE_W-1:0] == cur.node;
                        if (!cur.mute) begin
                            next_cur.rx_word = rx_done_word;
                            ev[ST_RXRDY]     = 1'b1;
                            ev[ST_PARITY_ERROR_FLAG]      = rx_parity_error_flag;
                        end else if (cur.ctrl[CTRL_WUM] && id_hit) begin
                            next_cur.mute = 1'b0;
                        end
                    end
                end
                default: next_cur.rx_st = LINE_IDLE;
            endcase
            // Idle line lasting a whole frame ends silence
            if (cur.mute && !cur.ctrl[CTRL_WUM] && cur.idle_bits >= nbits + 4'h2) begin
                next_cur.mute      = 1'b0;
                next_cur.idle_bits = 4'h0;
            end
        end

        // Unit disabled: line idles high, receiver parked
        if (!cur.ctrl[CTRL_UEN]) begin
            next_cur.txd       = 1'b1;
            next_cur.tx_st     = LINE_IDLE;
            next_cur.rx_st     = LINE_IDLE;
            next_cur.idle_bits = 4'h0;
        end

        // Sticky events: write one clears, a new event wins over the clear
        if (cur.wr_pend && cur.addr == OFS_STATUS) begin
            next_cur.status = cur.status & ~hwdata[EV_W-1:0];
        end
        next_cur.status = next_cur.status | ev;
        next_cur.irq    = |(next_cur.status & next_cur.mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur          <= '0;
            cur.rdy      <= 1'b1;
            cur.txd      <= 1'b1;
            cur.div      <= RST_DIV;
            cur.ctrl     <= RST_CTRL;
            cur.rx_word  <= RST_DATA[DATA_W-1:0];
            cur.tx_st    <= LINE_IDLE;
            cur.rx_st    <= LINE_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_data_upper_zero: assert property (@(posedge clk) disable iff (!resetn)
        cur.rd_pend && cur.addr == OFS_DATA |=> hreadyout && hrdata[31:9] == 23'h0)
        else $error("data register upper bits not zero");

    a_baud_upper_zero: assert property (@(posedge clk) disable iff (!resetn)
        cur.rd_pend && cur.addr == OFS_BAUD |=> hrdata == {16'h0, $past(cur.div)})
        else $error("baud register read wrong");

    a_baud_halted: assert property (@(posedge clk) disable iff (!resetn)
        !(cur.ctrl[CTRL_TEN] | cur.ctrl[CTRL_REN]) && !cur.wr_pend |=> $stable(cur.baud_cnt))
        else $error("baud counter ran while both directions off");

    a_idle_when_off: assert property (@(posedge clk) disable iff (!resetn)
        !cur.ctrl[CTRL_UEN] |=> txd && cur.rx_st == LINE_IDLE)
        else $error("line active while unit disabled");

    a_parity_insert: assert property (@(posedge clk) disable iff (!resetn)
        cur.tx_st == LINE_IDLE && next_cur.tx_st == LINE_START && cur.ctrl[CTRL_PEN] && !cur.ctrl[CTRL_WL]
        |=> cur.tx_sr[7] == ((^cur.tx_sr[6:0]) ^ cur.ctrl[CTRL_PSEL]))
        else $error("transmit parity bit wrong");

    a_parity_error_flag_sets: assert property (@(posedge clk) disable iff (!resetn)
        rx_done && !cur.mute && rx_parity_error_flag |=> cur.status[ST_PARITY_ERROR_FLAG] ##1 cur.irq == cur.mask[ST_PARITY_ERROR_FLAG] || cur.irq)
        else $error("parity error flag not set");

    a_word_8bit: assert property (@(posedge clk) disable iff (!resetn)
        rx_done && !cur.mute && !cur.ctrl[CTRL_WL] |=> cur.rx_word[8] == 1'b0 && cur.status[ST_RXRDY])
        else $error("8-bit word has ninth bit set");

    a_idle_wakeup: assert property (@(posedge clk) disable iff (!resetn)
        run && cur.ctrl[CTRL_REN] && cur.mute && !cur.ctrl[CTRL_WUM] && !cur.wr_pend
        && cur.idle_bits >= nbits + 4'h2 |=> !cur.mute)
        else $error("idle line did not end silence");

    a_stop_bit_high: assert property (@(posedge clk) disable iff (!resetn)
        cur.tx_st == LINE_STOP |-> txd)
        else $error("stop bit not high");

    a_read_one_wait: assert property (@(posedge clk) disable iff (!resetn)
        cur.rd_pend |-> !hreadyout ##1 hreadyout)
        else $error("read wait state not one cycle");

    a_rx_parity_msb: assert property (@(posedge clk) disable iff (!resetn)
        rx_done && cur.ctrl[CTRL_REN] && !cur.mute && cur.ctrl[CTRL_PEN] && !cur.ctrl[CTRL_WL]
        |=> cur.rx_word[7] == $past(cur.rx_sr[8]))
        else $error("received parity bit not in word MSB");

    a_no_false_parity_error_flag: assert property (@(posedge clk) disable iff (!resetn)
        rx_done && !rx_parity_error_flag && !cur.status[ST_PARITY_ERROR_FLAG] |=> !cur.status[ST_PARITY_ERROR_FLAG])
        else $error("parity error flag set on good frame");

endmodule // usart_core

//--- core/usart_core_pkg.sv
// Package: register map, field positions, reset values and states of the serial unit.
// Assumes a 32-bit AHB-Lite bus and one 125 MHz clock.
package usart_core_pkg;
    localparam logic [7:0]  OFS_STATUS   = 8'h00;
    localparam logic [7:0]  OFS_DATA     = 8'h04;
    localparam logic [7:0]  OFS_BAUD     = 8'h08;
    localparam logic [7:0]  OFS_CTRL     = 8'h0c;
    localparam logic [7:0]  OFS_MASK     = 8'h10;
    localparam logic [7:0]  OFS_ADDR     = 8'h14;
    // Control register fields
    localparam int          CTRL_UEN     = 13;
    localparam int          CTRL_WL      = 12;
    localparam int          CTRL_WUM     = 11;
    localparam int          CTRL_PEN     = 10;
    localparam int          CTRL_PSEL    = 9;
    localparam int          CTRL_TEN     = 3;
    localparam int          CTRL_REN     = 2;
    localparam int          CTRL_MUTE    = 1;
    localparam logic [13:0] CTRL_RW_MASK = 14'h3e0c;
    // Status fields; bits 0..2 are sticky events
    localparam int          ST_PARITY_ERROR_FLAG      = 0;
    localparam int          ST_RXRDY     = 1;
    localparam int          ST_TXDONE    = 2;
    localparam int          ST_MUTE      = 4;
    localparam int          EV_W         = 3;
    localparam int          DATA_W       = 9;
    localparam int          DIV_W        = 16;
    localparam int          NODE_W       = 4;
    localparam logic [31:0] RST_DATA     = 32'h0000_0000;
    localparam logic [15:0] RST_DIV      = 16'h0000;
    localparam logic [13:0] RST_CTRL     = 14'h0000;
    typedef enum logic [1:0] {
        LINE_IDLE  = 2'b00,
        LINE_START = 2'b01,
        LINE_DATA  = 2'b11,
        LINE_STOP  = 2'b10
    } line_state_t;
endpackage

//--- verif/serial_peer.sv
// Serial peer model: remote transceiver on the line, frames of start, n bits LSB first, one stop.
// Assumes DIV equals the divider written into the core; idle line is high.
`timescale 1ns/1ps

module serial_peer #(
    parameter int DIV = 8
) (
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    initial rxd = 1'b1;

    task automatic send(input logic [8:0] w, input int n);
        int i;
        @(posedge clk);
        rxd <= 1'b0;
        repeat (DIV) @(posedge clk);
        for (i = 0; i < n; i++) begin
            rxd <= w[i];
            repeat (DIV) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (DIV) @(posedge clk);
    endtask

    // Samples mid-bit on falling edges, away from the core's launch edge
    task automatic recv(input int n, output logic [8:0] w, output logic ok);
        int i;
        w = '0;
        ok = 1'b0;
        for (i = 0; i < 4000 && txd !== 1'b0; i++) @(negedge clk);
        if (txd !== 1'b0) return;
        repeat (DIV / 2) @(negedge clk);
        for (i = 0; i < n; i++) begin
            repeat (DIV) @(negedge clk);
            w[i] = txd;
        end
        repeat (DIV) @(negedge clk);
        ok = (txd === 1'b1);
    endtask
endmodule // serial_peer

//--- verif/tb_usart_core.sv
// Testbench: registers over AHB-Lite and serial frames of the serial unit core.
// Assumes the core package and the serial peer model.
`timescale 1ns/1ps

module tb_usart_core;
    import usart_core_pkg::*;
    localparam int DIV = 8;
    localparam logic [31:0] UE = 32'h1 << CTRL_UEN, TE = 32'h1 << CTRL_TEN, RE = 32'h1 << CTRL_REN,
        PE = 32'h1 << CTRL_PEN, PO = 32'h1 << CTRL_PSEL, W9 = 32'h1 << CTRL_WL,
        WA = 32'h1 << CTRL_WUM, MU = 32'h1 << CTRL_MUTE;
    logic        clk;
    logic        resetn;
    logic        hsel;
    logic        hwrite;
    logic        hreadyout;
    logic        hresp;
    logic        rxd;
    logic        txd;
    logic        irq;
    logic        ok;
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [8:0]  w;
    int          n_mismatch = 0;
    int          n_checks = 0;

    usart_core i_usart_core (
        .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rxd(rxd), .txd(txd), .irq(irq)
    );
    serial_peer #(.DIV(DIV)) i_serial_peer (.clk(clk), .txd(txd), .rxd(rxd));

    always #4 clk = ~clk;

    ////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Ready is sampled on the falling edge, so it is the value the next rising edge sees
    task automatic bus(input logic [7:0] a, input logic we, input logic [31:0] d, output logic [31:0] q);
        logic r;
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= we;
        do begin
            @(negedge clk);
            r = hreadyout;
            @(posedge clk);
        end while (r !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        do begin
            @(negedge clk);
            r = hreadyout;
            q = hrdata;
            @(posedge clk);
        end while (r !== 1'b1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        chk(nm, q, e);
    endtask

    task automatic quiet(input string nm);
        int i;
        ok = 1'b1;
        for (i = 0; i < 16 * DIV; i++) begin
            @(negedge clk);
            if (txd !== 1'b1) ok = 1'b0;
        end
        chk(nm, {31'h0, ok}, 32'h1);
    endtask

    // Bit 9 of d set means no new word is written, only the control
    task automatic tx(input logic [31:0] c, input logic [9:0] d, input int n, input logic [8:0] e);
        fork
            begin
                wr(OFS_CTRL, c);
                if (!d[9])
                    wr(OFS_DATA, {22'h0, d});
            end
            i_serial_peer.recv(n, w, ok);
        join
        // Let the stop bit end, else its done event lands after the next status clear
        repeat (2 * DIV) @(posedge clk);
        chk("tx word", {23'h0, w}, {23'h0, e});
        chk("tx stop", {31'h0, ok}, 32'h1);
    endtask

    task automatic rx(input logic [31:0] c, input logic [8:0] d, input int n, input logic [31:0] ed, es);
        wr(OFS_STATUS, 32'h7);
        wr(OFS_CTRL, c);
        i_serial_peer.send(d, n);
        repeat (4) @(posedge clk);
        rc(OFS_STATUS, es, "status");
        rc(OFS_DATA, ed, "rx word");
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        rc(OFS_DATA, 32'h0, "data reset");
        rc(OFS_BAUD, 32'h0, "baud reset");
        rc(OFS_CTRL, 32'h0, "ctrl reset");
        chk("txd reset", {31'h0, txd}, 32'h1);
        wr(OFS_CTRL, 32'hffff_fffd);
        rc(OFS_CTRL, {18'h0, CTRL_RW_MASK}, "ctrl fields");
        chk("hresp", {31'h0, hresp}, 32'h0);
        wr(OFS_CTRL, 32'h0);
        rc(8'h20, 32'h0, "unmapped");
        wr(OFS_DATA, 32'hffff_fe00);
        rc(OFS_DATA, 32'h0, "data upper");
        wr(OFS_BAUD, 32'hffff_0000 | DIV);
        rc(OFS_BAUD, DIV, "baud field");
        wr(OFS_MASK, 32'h1);
        rx(TE | RE, 9'h0a5, 8, 32'h0, 32'h0);
        wr(OFS_DATA, 32'h55);
        quiet("txd unit off");
        wr(OFS_CTRL, UE);
        quiet("txd counter off");
        tx(UE | TE, 10'h200, 8, 9'h055);
        tx(UE | TE | PE, 10'h083, 8, 9'h003);
        tx(UE | TE | PE | PO, 10'h083, 8, 9'h083);
        tx(UE | TE | W9, 10'h1aa, 9, 9'h1aa);
        tx(UE | TE | W9 | PE, 10'h1aa, 9, 9'h0aa);
        rx(UE | RE, 9'h05a, 8, 32'h5a, 32'h2);
        chk("irq masked", {31'h0, irq}, 32'h0);
        rx(UE | RE | PE, 9'h003, 8, 32'h3, 32'h2);
        rx(UE | RE | PE, 9'h083, 8, 32'h83, 32'h3);
        repeat (2) @(negedge clk);
        chk("irq set", {31'h0, irq}, 32'h1);
        wr(OFS_STATUS, 32'h1);
        repeat (2) @(negedge clk);
        chk("irq clear", {31'h0, irq}, 32'h0);
        rx(UE | RE | PE | PO, 9'h083, 8, 32'h83, 32'h2);
        rx(UE | RE | W9, 9'h1a5, 9, 32'h1a5, 32'h2);
        wr(OFS_ADDR, 32'h5);
        rx(UE | RE | WA | MU, 9'h033, 8, 32'h1a5, 32'h10);
        rx(UE | RE | WA, 9'h085, 8, 32'h1a5, 32'h0);
        wr(OFS_CTRL, UE | RE | MU);
        rc(OFS_STATUS, 32'h10, "silent entered");
        repeat (12 * DIV) @(posedge clk);
        rc(OFS_STATUS, 32'h0, "idle wake");
        print_verdict();
    end

    // Whole run needs well under 10000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
endmodule // tb_usart_core
